// [hdl/hub_port_defines.vh]
// hub port monitor constants: register map, fields, resets, timing
// definitions only; included by the monitor module
`ifndef HUB_PORT_DEFINES_VH
`define HUB_PORT_DEFINES_VH

// clock period of core_clk in ns
`define CLK_NS 50

// line_loss_interval bounds in ns
`define LINE_LOSS_MIN_NS 2000
`define LINE_LOSS_MAX_NS 2500

// detect hold after suspend or disable entry, in ms
`define HOLD_MS 4

// half period of indicator blinking, in ms
`define BLINK_MS 500

// register byte offsets
`define REG_CTRL    8'h00
`define REG_IND_SEL 8'h04
`define REG_STATUS  8'h08
`define REG_MASK    8'h0c
`define REG_LIVE    8'h10
`define REG_TRAITS  8'h14

// control fields and reset values
`define CTRL_PSW_BIT 0
`define CTRL_RST     1'h0
`define IND_SEL_RST  32'h0000_0000
`define STATUS_RST   16'h0000
`define MASK_RST     16'h0000

// status, mask and live field bases
`define ST_DISC_LSB 0
`define ST_OC_LSB   8
`define LIVE_K_LSB  8
`define LIVE_H_LSB  16

// hub_traits_field: indicator presence bit
`define TRAITS_IND_BIT 7

// per-port selector nibble
`define SEL_AUTO      2'h0
`define SEL_AMBER     2'h1
`define SEL_GREEN     2'h2
`define SEL_OFF       2'h3
`define SEL_BLINK_BIT 2

// port state codes from the port state machine
`define PS_POWERED_OFF    4'h0
`define PS_DISCONNECTED   4'h1
`define PS_DISABLED       4'h2
`define PS_RESETTING      4'h3
`define PS_TESTING        4'h4
`define PS_ENABLED        4'h5
`define PS_TRANSMIT       4'h6
`define PS_RESUME_REPEAT  4'h7
`define PS_SUSPENDED      4'h8
`define PS_RESUMING       4'h9
`define PS_END_OF_RESUME  4'ha
`define PS_RESTART_S      4'hb
`define PS_RESTART_E      4'hc

`endif

// [hdl/hub_port_monitor.v]
// hub downstream ports: full/low-speed disconnect timers and indicators
// assumes line, state and hub inputs are synchronous to core_clk and a
// port state machine elsewhere that consumes the detect levels
//
// Function
// RULE1 - every port has its own timer watching its single-ended lines.
// RULE2 - the timer clears on a J/idle line or outside the watched states.
// RULE3 - entry to suspended or disabled holds the timer clear for 4 ms.
// RULE4 - the timer fires after 2.0 to 2.5 us of steady SE0 or SE1.
// RULE5 - on expiry a disconnect level goes to the port state machine.
// RULE6 - the timer also filters short K in suspended and restart states.
// RULE7 - each indicator drives separate green and amber emitters.
// RULE8 - indicator presence is reported in bit 7 of hub_traits_field.
// RULE9 - in automatic mode hardware maps port state to colour.
// RULE10 - every colour selector returns to automatic on configuration.
// RULE11 - indicators are dark while the hub is suspended or unconfigured.
// RULE12 - with power switching the automatic map follows that column.
// RULE13 - without power switching the automatic map follows that column.
// RULE14 - manual mode shows the colour software wrote, auto the state.
// RULE15 - off, amber, green and off/colour blinking carry fixed meanings.
// RULE16 - the timer counts clock cycles to a threshold inside the range.
`include "hub_port_defines.vh"

module hub_port_monitor #(
  parameter NPORTS    = 4,
  parameter HAS_LEDS  = 1,
  parameter HOLD_CYC  = `HOLD_MS * 1000000 / `CLK_NS,
  parameter BLINK_CYC = `BLINK_MS * 1000000 / `CLK_NS
) (
  // clock and reset
  input  wire              core_clk,
  input  wire              rst,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // hub device state
  input  wire              hub_configured,
  input  wire              hub_suspended,
  // per-port inputs
  input  wire [4*NPORTS-1:0] port_state,
  input  wire [NPORTS-1:0] line_dp,
  input  wire [NPORTS-1:0] line_dm,
  input  wire [NPORTS-1:0] port_low_speed,
  input  wire [NPORTS-1:0] port_overcurrent,
  // per-port outputs
  output wire [NPORTS-1:0] disc_detect,
  output wire [NPORTS-1:0] k_persist,
  output wire [NPORTS-1:0] led_green,
  output wire [NPORTS-1:0] led_amber,
  // interrupt
  output reg               irq
);

  // min time rounds up; 40 cycles = 2.0 us, below the 2.5 us ceiling
  localparam DIS_CYC = (`LINE_LOSS_MIN_NS + `CLK_NS - 1) / `CLK_NS;
  // full-width copies so the narrow counters take a deliberate slice
  localparam [31:0] DIS_W    = DIS_CYC - 1;
  localparam [31:0] HOLD_W   = HOLD_CYC;
  localparam [31:0] BLINK_W  = BLINK_CYC - 1;
  localparam [5:0]  DIS_LIM  = DIS_W[5:0];
  localparam [23:0] HOLD_LD  = HOLD_W[23:0];
  localparam [23:0] BLINK_LD = BLINK_W[23:0];
  // limitation: a faster clock needs a wider tmr, and hold or blink
  // counts of 2**24 or more for hold, or above 2**24 for blink, would wrap in their 24-bit counters
  localparam [1:0]  CLS_J    = 2'h0;
  localparam [1:0]  CLS_SE0  = 2'h1;
  localparam [1:0]  CLS_SE1  = 2'h2;
  localparam [1:0]  CLS_K    = 2'h3;

  // single-ended line class; low speed swaps J and K polarity
  function [1:0] line_class;
    input dp;
    input dm;
    input ls;
    begin
      if (!dp && !dm)
        line_class = CLS_SE0;
      else if (dp && dm)
        line_class = CLS_SE1;
      else if (ls ? dp : dm)
        line_class = CLS_K;
      else
        line_class = CLS_J;
    end
  endfunction

  // states in which the disconnect timer may run
  function in_window;
    input [3:0] st;
    begin
      in_window = (st == `PS_ENABLED) || (st == `PS_SUSPENDED) ||
                  (st == `PS_DISABLED) || (st == `PS_RESTART_S) ||
                  (st == `PS_RESTART_E);
    end
  endfunction

  // RULE9 hardware colour map
  // RULE12 with power switching
  // RULE13 without power switching
  // automatic colour {amber, green}
  function [1:0] auto_colour;
    input [3:0] st;
    input       oc;
    input       psw;
    begin
      case (st)
        `PS_POWERED_OFF:
          auto_colour = (psw && oc) ? 2'h2 : 2'h0;
        `PS_DISCONNECTED, `PS_DISABLED, `PS_RESETTING, `PS_TESTING:
          auto_colour = (!psw && oc) ? 2'h2 : 2'h0;
        `PS_ENABLED, `PS_TRANSMIT, `PS_RESUME_REPEAT:
          auto_colour = 2'h1;
        default:
          auto_colour = 2'h0;
      endcase
    end
  endfunction

  // manual colour {amber, green}; green and amber never both lit
  function [1:0] man_colour;
    input [1:0] sel;
    begin
      case (sel)
        `SEL_AMBER: man_colour = 2'h2;
        `SEL_GREEN: man_colour = 2'h1;
        default:    man_colour = 2'h0;
      endcase
    end
  endfunction

  // byte-lane merge of a write into a register word
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  sel;
    reg   [31:0] bm;
    begin
      bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      wmerge = (old & ~bm) | (din & bm);
    end
  endfunction

  // bus decode
  wire        req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr    = req && wb_we_i;
  wire [7:0]  adr   = {wb_adr_i[7:2], 2'h0};
  wire [31:0] lanes = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);

  // software state
  reg         psw;
  reg  [31:0] ind_sel;
  reg  [15:0] status;
  reg  [15:0] mask;
  reg         cfg_q;
  reg  [23:0] blink_cnt;
  reg         blink_ph;
  // mask merge keeps the lane rules; the upper half is dropped on purpose
  wire [31:0] mask_wr = wmerge({16'h0000, mask}, wb_dat_i, wb_sel_i);

  // padded per-port views for the register file
  wire [7:0] det8;
  wire [7:0] kp8;
  wire [7:0] hact8;
  wire [7:0] dev8;
  wire [7:0] oev8;
  wire       cfg_rise = hub_configured && !cfg_q;
  // boards without emitters keep both drives low
  wire       dark = !hub_configured || hub_suspended || (HAS_LEDS == 0);

  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1) begin : port
      wire [3:0] st    = port_state[4*g +: 4];
      wire [1:0] cls   = line_class(line_dp[g], line_dm[g], port_low_speed[g]);
      wire       is_k  = (cls == CLS_K);
      wire       filt  = (st == `PS_SUSPENDED) || (st == `PS_RESTART_S) ||
                         (st == `PS_RESTART_E);
      reg  [3:0] prev_st;
      reg [23:0] hold;
      reg  [5:0] tmr;
      reg        kind_k;
      reg        det;
      reg        kp;
      reg        oc_q;
      reg        led_g;
      reg        led_a;
      wire       entry = ((st == `PS_SUSPENDED) || (st == `PS_DISABLED)) &&
                         (st != prev_st);
      // RULE2 timer clear conditions
      wire       live  = in_window(st) && !entry && (hold == 24'h000000) &&
                         (cls != CLS_J) && (!is_k || filt);
      // RULE4 steady class for the whole interval
      wire       full  = live && (is_k == kind_k) && (tmr == DIS_LIM);
      wire [3:0] sel   = ind_sel[4*g +: 4];
      wire [1:0] base  = (sel[1:0] == `SEL_AUTO) ?
                         auto_colour(st, port_overcurrent[g], psw) :
                         man_colour(sel[1:0]);
      // RULE15 blink gates colour off
      wire [1:0] shown = (dark || (sel[`SEL_BLINK_BIT] && !blink_ph)) ?
                         2'h0 : base;

      // RULE3 hold clear after suspend or disable entry
      always @(posedge core_clk) begin
        if (rst) begin
          prev_st <= `PS_POWERED_OFF;
          hold    <= 24'h000000;
        end else begin
          prev_st <= st;
          if (entry)
            hold <= HOLD_LD;
          else if (hold != 24'h000000)
            hold <= hold - 24'h000001;
        end
      end

      // a K/SE switch restarts the count, so the first cycle after a
      // class change only reloads kind_k; worst case 41 cycles, 2.05 us
      // RULE1 per-port timer
      // RULE16 cycle count against fixed threshold
      always @(posedge core_clk) begin
        if (rst) begin
          tmr    <= 6'h00;
          kind_k <= 1'b0;
        end else begin
          kind_k <= is_k;
          if (!live || (is_k != kind_k))
            tmr <= 6'h00;
          else if (tmr != DIS_LIM)
            tmr <= tmr + 6'h01;
        end
      end

      // RULE5 disconnect level
      // RULE6 long K through the same timer
      always @(posedge core_clk) begin
        if (rst) begin
          det  <= 1'b0;
          kp   <= 1'b0;
          oc_q <= 1'b0;
        end else begin
          det  <= full && !is_k;
          kp   <= full && is_k;
          oc_q <= port_overcurrent[g];
        end
      end

      // RULE7 separate green and amber drives
      // RULE11 dark when hub suspended or unconfigured
      always @(posedge core_clk) begin
        if (rst) begin
          led_g <= 1'b0;
          led_a <= 1'b0;
        end else begin
          led_g <= shown[0];
          led_a <= shown[1];
        end
      end

      assign disc_detect[g] = det;
      assign k_persist[g]   = kp;
      assign led_green[g]   = led_g;
      assign led_amber[g]   = led_a;
      assign det8[g]        = det;
      assign kp8[g]         = kp;
      assign hact8[g]       = (hold != 24'h000000);
      assign dev8[g]        = full && !is_k && !det;
      assign oev8[g]        = port_overcurrent[g] && !oc_q;
    end
    // unused port slots read as zero
    for (g = NPORTS; g < 8; g = g + 1) begin : pad
      assign det8[g]  = 1'b0;
      assign kp8[g]   = 1'b0;
      assign hact8[g] = 1'b0;
      assign dev8[g]  = 1'b0;
      assign oev8[g]  = 1'b0;
    end
  endgenerate

  // blink enable divider; phase toggles each half period
  always @(posedge core_clk) begin
    if (rst) begin
      blink_cnt <= 24'h000000;
      blink_ph  <= 1'b0;
    end else if (blink_cnt == BLINK_LD) begin
      blink_cnt <= 24'h000000;
      blink_ph  <= !blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 24'h000001;
    end
  end

  // control register: power switching steers the automatic map
  always @(posedge core_clk) begin
    if (rst)
      psw <= `CTRL_RST;
    else if (wr && (adr == `REG_CTRL) && wb_sel_i[0])
      psw <= wb_dat_i[`CTRL_PSW_BIT];
  end

  // RULE10 selectors back to automatic on configuration
  // RULE14 manual selector written by software
  // configuration wins over a same-cycle write
  always @(posedge core_clk) begin
    if (rst) begin
      ind_sel <= `IND_SEL_RST;
      cfg_q   <= 1'b0;
    end else begin
      cfg_q <= hub_configured;
      if (cfg_rise)
        ind_sel <= 32'h0000_0000;
      else if (wr && (adr == `REG_IND_SEL))
        ind_sel <= wmerge(ind_sel, wb_dat_i, wb_sel_i);
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  // an over-current level still high at reset release counts once
  always @(posedge core_clk) begin
    if (rst) begin
      status <= `STATUS_RST;
      mask   <= `MASK_RST;
    end else begin
      if (wr && (adr == `REG_STATUS))
        status <= (status & ~lanes[15:0]) | {oev8, dev8};
      else
        status <= status | {oev8, dev8};
      if (wr && (adr == `REG_MASK))
        mask <= mask_wr[15:0];
    end
  end

  // level interrupt from unmasked sticky bits
  always @(posedge core_clk) begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  // read mux; unmapped offsets read zero
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0000_0000;
    case (adr)
      `REG_CTRL:    rd_word[`CTRL_PSW_BIT] = psw;
      `REG_IND_SEL: rd_word = ind_sel;
      `REG_STATUS:  rd_word[15:0] = status;
      `REG_MASK:    rd_word[15:0] = mask;
      `REG_LIVE:    rd_word[23:0] = {hact8, kp8, det8};
      // RULE8 indicator presence bit
      `REG_TRAITS:  rd_word[`TRAITS_IND_BIT] = (HAS_LEDS != 0);
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // one-cycle ack for every access, mapped or not
  // req masks a still-held strobe, so ack never stands two cycles
  always @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= rd_word;
    end
  end

endmodule // hub_port_monitor

// [tb/hub_port_checker.sv]
// assertions on port 0 timer and indicators; only the one-colour check covers all ports
// assumes the defines header is on the include path
`include "hub_port_defines.vh"
module hub_port_checker #(
  parameter NPORTS   = 4,
  parameter HOLD_CYC = 20
) (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rst,
  // hub and port inputs
  input wire logic                hub_configured,
  input wire logic                hub_suspended,
  input wire logic [4*NPORTS-1:0] port_state,
  input wire logic [NPORTS-1:0]   line_dp,
  input wire logic [NPORTS-1:0]   line_dm,
  // port outputs
  input wire logic [NPORTS-1:0]   disc_detect,
  input wire logic [NPORTS-1:0]   k_persist,
  input wire logic [NPORTS-1:0]   led_green,
  input wire logic [NPORTS-1:0]   led_amber
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  st;
  logic [3:0]  st_q;
  logic        se;
  logic        win;
  logic        sd;
  logic [15:0] run;
  logic [15:0] hold;
  // decode of port 0 line and state
  assign st  = port_state[3:0];
  assign se  = line_dp[0] == line_dm[0];
  assign sd  = st == `PS_SUSPENDED || st == `PS_DISABLED;
  assign win = sd || st == `PS_ENABLED || st == `PS_RESTART_S || st == `PS_RESTART_E;
  // run: steady SE edges in window; hold: edges since suspend/disable entry
  always @(posedge core_clk) begin
    st_q <= st;
    if (rst || !(se && win))
      run <= 16'h0;
    else if (run != 16'hffff)
      run <= run + 16'h1;
    if (rst)
      hold <= 16'hffff;
    else if (sd && st != st_q)
      hold <= 16'h0;
    else if (hold != 16'hffff)
      hold <= hold + 16'h1;
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence cfg_rise;
    $rose(hub_configured) && !hub_suspended && st == `PS_ENABLED;
  endsequence
  sequence cfg_keep;
    hub_configured && !hub_suspended && st == `PS_ENABLED;
  endsequence
  timer_clear_a: assert property (
    (!se || !win) |=> !disc_detect[0]) else $error("detect kept after idle line");
  timer_hold_a: assert property (
    (sd && hold < HOLD_CYC + 40) |-> !disc_detect[0]) else $error("detect during hold");
  detect_early_a: assert property (
    $rose(disc_detect[0]) |-> run >= 40) else $error("detect too early");
  detect_late_a: assert property (
    (run >= 41 && st == `PS_ENABLED) |-> disc_detect[0]) else $error("detect too late");
  k_filter_a: assert property (
    k_persist[0] |-> !$past(se) && $past(st) >= `PS_SUSPENDED && $past(st) != `PS_RESUMING
    && $past(st) != `PS_END_OF_RESUME) else $error("k persist outside filter states");
  leds_dark_a: assert property (
    (!hub_configured || hub_suspended) |=> !led_green[0] && !led_amber[0])
    else $error("led lit while hub idle");
  one_colour_a: assert property (
    (led_green & led_amber) == 0) else $error("both colours lit");
  config_auto_a: assert property (
    cfg_rise ##1 cfg_keep |=> led_green[0] && !led_amber[0]) else $error("no auto on config");
endmodule // hub_port_checker

bind hub_port_monitor hub_port_checker #(.NPORTS(NPORTS), .HOLD_CYC(HOLD_CYC)) i_chk (
  .core_clk(core_clk), .rst(rst), .hub_configured(hub_configured),
  .hub_suspended(hub_suspended), .port_state(port_state), .line_dp(line_dp),
  .line_dm(line_dm), .disc_detect(disc_detect), .k_persist(k_persist),
  .led_green(led_green), .led_amber(led_amber));

// [tb/hub_port_disconnect_and_indicator_tb_top.sv]
// bench for the hub port monitor: bus, indicator map, line timer
// assumes the defines header on the include path; hold and blink shortened
`include "hub_port_defines.vh"
module hub_port_disconnect_and_indicator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 20;
  logic        core_clk, rst, cyc, stb, we, ack, irq, cfg, susp;
  logic [7:0]  adr, mode;
  logic [31:0] wdat, rdat, dat_o;
  logic [15:0] pstate;
  logic [3:0]  oc, dp, dm, disc, kp, grn, amb, ls;
  int          err_total = 0, compares = 0, cycles = 0;
  // psw, overcurrent, state code, green, amber
  logic [7:0]  rows [16] = '{8'hc1, 8'h80, 8'hc4, 8'h45, 8'h40, 8'h16, 8'h9a, 8'h1e,
                             8'ha0, 8'h24, 8'ha8, 8'h6c, 8'h51, 8'h8c, 8'h08, 8'hb0};
  hub_port_monitor #(.HOLD_CYC(HOLD), .BLINK_CYC(4)) i_hub_port_monitor (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .hub_configured(cfg), .hub_suspended(susp), .port_state(pstate), .line_dp(dp),
    .line_dm(dm), .port_low_speed(ls), .port_overcurrent(oc), .disc_detect(disc),
    .k_persist(kp), .led_green(grn), .led_amber(amb), .irq(irq));
  usb_dev_model i_usb_dev_model (.mode(mode), .low_speed(ls), .line_dp(dp), .line_dm(dm));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // classic cycle held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    // registered ack: one edge takes the request, the next sees ack
    chk("ack latency", 2, n);
  endtask
  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    int n;
    {rst, cyc, stb, we, cfg, susp} = 6'h20;
    {adr, mode, wdat, pstate, oc, ls} = 0;
    tick(4);
    rst <= 1'b0;
    cfg <= 1'b1;
    // automatic colour table, both power switching columns
    foreach (rows[i]) begin
      wb(1'b1, `REG_CTRL, {31'h0, rows[i][7]});
      oc <= {3'h0, rows[i][6]};
      pstate <= {12'h0, rows[i][5:2]};
      tick(2);
      chk("auto colour", rows[i][1:0], {grn[0], amb[0]});
    end
    // read-only traits ignore writes; unmapped reads zero
    wb(1'b1, `REG_TRAITS, 32'hffff_ffff);
    wb(1'b0, `REG_TRAITS, 32'h0);
    chk("traits", 32'h1 << `TRAITS_IND_BIT, rdat);
    wb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 0, rdat);
    // manual amber, green, off
    pstate <= {12'h0, `PS_ENABLED};
    for (int c = 1; c < 4; c++) begin
      wb(1'b1, `REG_IND_SEL, 32'(c));
      tick(2);
      chk("manual", {c == 2, c == 1}, {grn[0], amb[0]});
    end
    // blinking green: half period 4, so 8 lit of 16
    wb(1'b1, `REG_IND_SEL, 32'h6);
    n = 0;
    repeat (16) begin
      tick(1);
      n += grn[0];
    end
    chk("blink", 8, n);
    susp <= 1'b1;
    tick(2);
    chk("dark suspended", 0, {grn, amb});
    {susp, cfg} <= 2'h0;
    tick(2);
    chk("dark unconfigured", 0, {grn, amb});
    cfg <= 1'b1;
    wb(1'b0, `REG_IND_SEL, 32'h0);
    chk("selector", `IND_SEL_RST, rdat);
    // SE0 then SE1 counts as one run of forty cycles
    wb(1'b1, `REG_MASK, 32'h1);
    mode <= 8'h01;
    tick(20);
    mode <= 8'h03;
    tick(20);
    chk("disc early", 0, disc[0]);
    tick(1);
    chk("disc", 1, disc[0]);
    tick(1);
    chk("irq", 1, irq);
    mode <= 8'h00;
    wb(1'b0, `REG_STATUS, 32'h0);
    // over-current rise from the colour table stays sticky in bit 8
    chk("status", 32'h0000_0101, rdat);
    wb(1'b1, `REG_STATUS, 32'h1);
    tick(2);
    chk("irq clear", 0, irq);
    // short pulse is filtered
    mode <= 8'h01;
    tick(30);
    mode <= 8'h00;
    tick(15);
    chk("short pulse", 0, disc[0]);
    // suspend entry holds the timer, then SE0 counts
    pstate <= {12'h0, `PS_SUSPENDED};
    mode <= 8'h01;
    tick(HOLD + 41);
    chk("held", 0, disc[0]);
    tick(1);
    chk("after hold", 1, disc[0]);
    // low-speed pair: K sits on the plus line
    mode <= 8'h02;
    ls <= 4'h1;
    tick(45);
    chk("k filter", 2, {kp[0], disc[0]});
    wb(1'b0, `REG_LIVE, 32'h0);
    chk("live", 32'h0000_0100, rdat);
    pstate <= {12'h0, `PS_ENABLED};
    tick(45);
    chk("k enabled", 0, kp[0]);
    pstate <= {12'h0, `PS_RESETTING};
    mode <= 8'h01;
    tick(50);
    chk("outside window", 0, disc[0]);
    // mid-run reset: outputs and software registers back to defaults
    rst <= 1'b1;
    tick(2);
    chk("reset outputs", 0, {irq, kp, disc, grn, amb});
    rst <= 1'b0;
    wb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl reset", `CTRL_RST, rdat);
    wb(1'b0, `REG_MASK, 32'h0);
    chk("mask reset", `MASK_RST, rdat);
    complete_run();
  end
endmodule // hub_port_disconnect_and_indicator_tb_top

// [tb/usb_dev_model.sv]
// attached device model: drives the line pair of each port
// assumes the bench steps mode just after a rising edge
module usb_dev_model #(
  parameter NPORTS = 4
) (
  // per port: 0 idle J, 1 SE0, 2 K, 3 SE1
  input  wire logic [2*NPORTS-1:0] mode,
  input  wire logic [NPORTS-1:0]   low_speed,
  // single-ended lines
  output logic      [NPORTS-1:0]   line_dp,
  output logic      [NPORTS-1:0]   line_dm
);
  timeunit 1ns;
  timeprecision 1ns;
  // low speed swaps the pair, so J sits on the pulled-up line
  always_comb begin
    for (int g = 0; g < NPORTS; g++) begin
      case (mode[2*g +: 2])
        2'h0: {line_dp[g], line_dm[g]} = {!low_speed[g], low_speed[g]};
        2'h1: {line_dp[g], line_dm[g]} = 2'h0;
        2'h2: {line_dp[g], line_dm[g]} = {low_speed[g], !low_speed[g]};
        default: {line_dp[g], line_dm[g]} = 2'h3;
      endcase
    end
  end
endmodule // usb_dev_model
